// ---- src/sfw_pkg.sv ----
// Constants shared by the serial-flash status and write-permission block.
// Assumes a 40 MHz system clock and a serial link clocked by the host.
package sfw_pkg;
    // ==========================================
    // Command codes
    localparam logic [7:0] CMD_WR_GRANT = 8'h06;
    localparam logic [7:0] CMD_WR_REVOKE = 8'h04;
    localparam logic [7:0] CMD_ID_READ = 8'h9F;
    localparam logic [7:0] CMD_ST_READ = 8'h05;
    localparam logic [7:0] CMD_ST_WRITE = 8'h01;
    // ==========================================
    // Status byte field positions
    localparam int ST_BUSY = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_LVL_LO = 2;
    localparam int ST_LVL_MID = 3;
    localparam int ST_LOCK = 7;
    // Reset values
    localparam logic ST_LOCK_RST = 1'b0;
    localparam logic [1:0] ST_LVL_RST = 2'h0;
    localparam logic ST_LATCH_RST = 1'b0;
    // Fixed non-volatile bits with no write path
    localparam logic LVL_HI_NV = 1'b0;
    localparam logic FROM_BOTTOM_NV = 1'b0;
    // ==========================================
    // Frame bit counts
    localparam logic [7:0] CMD_BITS = 8'h08;
    localparam logic [7:0] WRSR_BITS = 8'h10;
    localparam logic [7:0] ID_END = 8'hA8;
    localparam logic [7:0] ID_LAST = 8'h9F;
    localparam logic [7:0] SAT_CNT = 8'hFF;
    // Identification contents; the code value is arbitrary
    localparam logic [23:0] ID_CODE_DEF = 24'hA5_5A01;
    localparam logic [7:0] FACT_LEN = 8'h10;
    localparam logic [127:0] FACT_DEF = 128'h0;
    // ==========================================
    // Self-timed cycle durations
    localparam int CLK_MHZ = 40;
    localparam int T_W_US = 1000;
    localparam int T_OP_US = 1000;
    localparam int T_W_CYC = T_W_US * CLK_MHZ;
    localparam int T_OP_CYC = T_OP_US * CLK_MHZ;
    // Sectors in the array
    localparam logic [6:0] N_SECTORS = 7'h10;
    // Self-timed cycle kinds
    typedef enum logic [1:0] {CY_IDLE, CY_STATUS, CY_ARRAY} sfw_cyc_e;
endpackage

// ---- src/sfw_status_ctrl.sv ----
// Serial-flash command logic: write-permission latch, identification,
// status read and status write with software and hardware protection.
// Assumes the host drives select, serial clock and serial input; the
// program/erase engine sits outside and asks through OP_REQ_I.
`timescale 1ns/1ps
module sfw_status_ctrl
#(
    parameter int unsigned T_W_CYC = sfw_pkg::T_W_CYC,
    parameter int unsigned T_OP_CYC = sfw_pkg::T_OP_CYC,
    parameter logic [23:0] ID_CODE = sfw_pkg::ID_CODE_DEF,
    parameter logic [127:0] FACT_DATA = sfw_pkg::FACT_DEF
)
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic SCK_I,
    input wire logic SEL_B_I,
    input wire logic SERIAL_IN_LINE_I,
    input wire logic WP_B_I,
    input wire logic OP_REQ_I,
    input wire logic OP_WHOLE_I,
    input wire logic [3:0] OP_SECTOR_I,
    output logic SERIAL_OUT_LINE_O,
    output logic SERIAL_OUT_LINE_OE_O,
    output logic OP_GO_O,
    output logic [7:0] STATUS_O,
    output logic HW_LOCKED_STATE_O,
    output logic SW_GUARDED_STATE_O,
    output logic [2:0] PROTECT_LEVEL_O,
    output logic PROTECT_FROM_BOTTOM_O
);
    import sfw_pkg::*;

    // ==========================================
    // Link domain: frame capture on the serial clock
    logic fr_q;
    logic tog_q;
    logic ovf_q;
    logic id_ok_q;
    logic [7:0] cnt_q;
    logic [7:0] cmd_q;
    logic [7:0] dat_q;
    logic [7:0] st_meta_q;
    logic [7:0] st_sync_q;
    logic so_q;
    logic oe_q;
    logic [7:0] status;

    // Select high or power-up clears the frame-open flag and the output registers at once
    wire frm_rst_b = RST_B_I & ~SEL_B_I;
    wire in_cmd = ~fr_q | (cnt_q < CMD_BITS);
    wire [7:0] cnt_d = fr_q ? 8'(cnt_q + 8'h01) : 8'h01;
    wire ovf_d = fr_q & (ovf_q | (cnt_q == SAT_CNT));
    wire [7:0] cmd_d = in_cmd ? {cmd_q[6:0], SERIAL_IN_LINE_I} : cmd_q;
    wire [7:0] dat_d = in_cmd ? dat_q : {dat_q[6:0], SERIAL_IN_LINE_I};
    // Busy snapshot taken on the eighth command bit
    wire id_ok_d = (fr_q && cnt_q == 8'(CMD_BITS - 8'h01)) ? ~st_sync_q[ST_BUSY] : id_ok_q;

    // Frame-open flag, dropped asynchronously by select
    always_ff @(posedge SCK_I or negedge frm_rst_b)
    begin
        if (!frm_rst_b)
            fr_q <= 1'b0;
        else
            fr_q <= 1'b1;
    end

    // Shift and count on rising serial clock
    always_ff @(posedge SCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            cnt_q <= 8'h00;
            ovf_q <= 1'b0;
            cmd_q <= 8'h00;
            dat_q <= 8'h00;
            id_ok_q <= 1'b0;
            tog_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
            cmd_q <= cmd_d;
            dat_q <= dat_d;
            id_ok_q <= id_ok_d;
            tog_q <= fr_q ? tog_q : ~tog_q;
        end
    end

    // Status byte brought into the link domain, two flops per bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_st_sync
            always_ff @(posedge SCK_I or negedge RST_B_I)
            begin
                if (!RST_B_I)
                begin
                    st_meta_q[gi] <= 1'b0;
                    st_sync_q[gi] <= 1'b0;
                end
                else
                begin
                    st_meta_q[gi] <= status[gi];
                    st_sync_q[gi] <= st_meta_q[gi];
                end
            end
        end
    endgenerate

    // Read-out selection
    wire [159:0] id_stream = {ID_CODE, FACT_LEN, FACT_DATA};
    wire [7:0] id_idx = 8'(cnt_q - CMD_BITS);
    wire id_live = ~ovf_q & (cnt_q < ID_END);
    wire is_rdsr = (cmd_q == CMD_ST_READ);
    wire is_id = (cmd_q == CMD_ID_READ) & id_ok_q;
    wire data_on = fr_q & (ovf_q | cnt_q >= CMD_BITS);
    wire oe_d = data_on & (is_rdsr | is_id);
    // Status repeats every byte; identification ends in zeros
    wire so_d = is_rdsr ? st_sync_q[~cnt_q[2:0]]
        : (id_live ? id_stream[8'(ID_LAST - id_idx)] : 1'b0);

    // Output bits change on falling serial clock
    always_ff @(negedge SCK_I or negedge frm_rst_b)
    begin
        if (!frm_rst_b)
        begin
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else
        begin
            so_q <= so_d;
            oe_q <= oe_d;
        end
    end

    assign SERIAL_OUT_LINE_O = so_q;
    assign SERIAL_OUT_LINE_OE_O = oe_q;

    // ==========================================
    // System domain: synchronisers and command execution
    logic sel_m_q;
    logic sel_s_q;
    logic sel_p_q;
    logic wp_m_q;
    logic wp_s_q;
    logic seen_q;
    logic latch_q;
    logic lock_q;
    logic go_q;
    logic [1:0] lvl_q;
    logic [23:0] tmr_q;
    sfw_cyc_e cyc_q;
    sfw_cyc_e cyc_d;

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sel_m_q <= 1'b1;
            sel_s_q <= 1'b1;
            sel_p_q <= 1'b1;
            wp_m_q <= 1'b1;
            wp_s_q <= 1'b1;
        end
        else
        begin
            sel_m_q <= SEL_B_I;
            sel_s_q <= sel_m_q;
            sel_p_q <= sel_s_q;
            wp_m_q <= WP_B_I;
            wp_s_q <= wp_m_q;
        end
    end

    // Frame decode; link registers are frozen once select has risen
    wire sel_rise = sel_s_q & ~sel_p_q;
    wire new_frm = sel_rise & (tog_q != seen_q);
    wire idle = (cyc_q == CY_IDLE);
    wire end8 = new_frm & ~ovf_q & (cnt_q == CMD_BITS);
    wire end16 = new_frm & ~ovf_q & (cnt_q == WRSR_BITS);
    wire wren_hit = end8 & (cmd_q == CMD_WR_GRANT) & idle;
    wire wrdi_hit = end8 & (cmd_q == CMD_WR_REVOKE) & idle;
    wire wrsr_hit = end16 & (cmd_q == CMD_ST_WRITE) & idle;
    wire hw_locked = lock_q & ~wp_s_q;
    wire wrsr_ok = wrsr_hit & latch_q & ~hw_locked;
    wire [2:0] lvl = {LVL_HI_NV, lvl_q};
    // Region size in sectors: none at level 0, else 2^(level-1)
    wire [6:0] reg_n = (lvl == 3'h0) ? 7'h00 : 7'(7'h01 << (lvl - 3'h1));
    wire in_top = 7'(N_SECTORS - {3'h0, OP_SECTOR_I}) <= reg_n;
    wire in_bot = {3'h0, OP_SECTOR_I} < reg_n;
    wire op_prot = FROM_BOTTOM_NV ? in_bot : in_top;
    wire op_allow = OP_WHOLE_I ? (lvl == 3'h0) : ~op_prot;
    wire op_ok = OP_REQ_I & latch_q & idle & ~wrsr_ok & op_allow;
    wire [23:0] tmr_last = (cyc_q == CY_STATUS) ? 24'(T_W_CYC - 1) : 24'(T_OP_CYC - 1);
    wire done = ~idle & (tmr_q == tmr_last);

    // Self-timed cycle sequencing
    always_comb
    begin
        cyc_d = cyc_q;
        case (cyc_q)
            CY_IDLE:
            begin
                if (wrsr_ok)
                    cyc_d = CY_STATUS;
                else if (op_ok)
                    cyc_d = CY_ARRAY;
            end
            CY_STATUS, CY_ARRAY:
            begin
                if (done)
                    cyc_d = CY_IDLE;
            end
            default:
                cyc_d = CY_IDLE;
        endcase
    end

    // Latch, status fields, timer and grant pulse
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            cyc_q <= CY_IDLE;
            tmr_q <= 24'h00_0000;
            latch_q <= ST_LATCH_RST;
            lock_q <= ST_LOCK_RST;
            lvl_q <= ST_LVL_RST;
            seen_q <= 1'b0;
            go_q <= 1'b0;
        end
        else
        begin
            cyc_q <= cyc_d;
            tmr_q <= idle ? 24'h00_0000 : 24'(tmr_q + 24'h00_0001);
            seen_q <= sel_rise ? tog_q : seen_q;
            go_q <= op_ok;
            if (wren_hit)
                latch_q <= 1'b1;
            else if (wrdi_hit | done)
                latch_q <= 1'b0;
            if (wrsr_ok)
            begin
                lock_q <= dat_q[ST_LOCK];
                lvl_q <= dat_q[ST_LVL_MID:ST_LVL_LO];
            end
        end
    end

    // Status byte and side outputs
    assign status = {lock_q, 3'h0, lvl_q, latch_q, ~idle};
    assign STATUS_O = status;
    assign OP_GO_O = go_q;
    assign HW_LOCKED_STATE_O = hw_locked;
    assign SW_GUARDED_STATE_O = ~hw_locked;
    assign PROTECT_LEVEL_O = lvl;
    assign PROTECT_FROM_BOTTOM_O = FROM_BOTTOM_NV;

    // ==========================================
    // Assertions
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    a_grant_sets: assert property (wren_hit |=> latch_q)
        else $error("grant did not set latch");
    a_grant_len: assert property (sel_rise && cnt_q != CMD_BITS && !latch_q && idle
        |=> !latch_q)
        else $error("latch set without an exact byte");
    a_revoke_clr: assert property (wrdi_hit |=> !latch_q)
        else $error("revoke did not clear latch");
    a_wrsr_refuse: assert property (wrsr_hit && !latch_q |=> idle && $stable(lock_q))
        else $error("status write ran without latch");
    a_lock_refuse: assert property (wrsr_hit && hw_locked
        |=> $stable(lvl_q) && cyc_q != CY_STATUS)
        else $error("status write ran in locked state");
    a_wrsr_busy: assert property (wrsr_ok |=> status[ST_BUSY] [*8])
        else $error("busy not held after status write");
    a_done_clear: assert property ($fell(status[ST_BUSY]) |-> !latch_q)
        else $error("latch left set after cycle");
    a_zero_bits: assert property (status[6:4] == 3'h0)
        else $error("reserved status bits not zero");
    a_whole_guard: assert property (OP_GO_O && $past(OP_WHOLE_I) |-> lvl == 3'h0)
        else $error("whole erase granted while protected");
    a_go_busy: assert property (OP_GO_O |-> cyc_q == CY_ARRAY && $past(latch_q))
        else $error("array grant without latch");
    a_lock_exit: assert property (WP_B_I && $past(WP_B_I) && $past(WP_B_I, 2)
        |-> !hw_locked)
        else $error("locked with protect pin high");

    c_grant: cover property (wren_hit);
    c_wrsr: cover property (wrsr_ok);
    c_done: cover property (done && cyc_q == CY_STATUS);
    c_op: cover property (OP_GO_O);
endmodule

// ---- testbench/sfw_host_model.sv ----
// Host controller model: drives select, serial clock and serial input.
// Assumes the device answers on its serial output after falling clock.
`timescale 1ns/1ps
module sfw_host_model
(
    output logic sck_o,
    output logic sel_b_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // ==========================================
    // Idle link: clock still, select high
    initial
    begin
        sck_o = 1'b0;
        sel_b_o = 1'b1;
        mosi_o = 1'b0;
    end

    // ==========================================
    // One frame: nbits of tx MSB first, answer bits taken on rising clock
    // No power-down command exists here, so identification never meets it
    task automatic frame(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
        rx = '0;
        sel_b_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            mosi_o = tx[47 - i];
            #40;
            sck_o = 1'b1;
            rx = {rx[46:0], miso_i};
            #40;
            sck_o = 1'b0;
        end
        #20;
        sel_b_o = 1'b1;
        mosi_o = ~mosi_o;
        #200; // Select high gap, callers wait out busy before writes
    endtask
endmodule

// ---- testbench/sfw_status_ctrl_tb.sv ----
// Self-checking bench for the status and write-permission block.
// Assumes the host model in sfw_host_model drives the serial link.
`timescale 1ns/1ps
module sfw_status_ctrl_tb;
    import sfw_pkg::*;
    localparam int unsigned TW = 20;
    localparam int unsigned TOP = 200;
    logic clk, rst_b, sck, sel_b, si, wp_b, op_req, op_whole;
    logic so, so_oe, op_go, hw_lck, sw_grd, bot;
    logic [3:0] op_sector;
    logic [7:0] status;
    logic [2:0] lvl;
    logic [47:0] rx;
    wire so_wire;
    int mismatches, checked;

    // ==========================================
    // Released out line shows the inverse of its last value
    assign so_wire = so_oe ? so : ~so;

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    sfw_host_model host_u (.sck_o(sck), .sel_b_o(sel_b), .mosi_o(si), .miso_i(so_wire));

    sfw_status_ctrl #(.T_W_CYC(TW), .T_OP_CYC(TOP)) dut_u (
        .CLK_I(clk), .RST_B_I(rst_b), .SCK_I(sck), .SEL_B_I(sel_b),
        .SERIAL_IN_LINE_I(si), .WP_B_I(wp_b), .OP_REQ_I(op_req),
        .OP_WHOLE_I(op_whole), .OP_SECTOR_I(op_sector),
        .SERIAL_OUT_LINE_O(so), .SERIAL_OUT_LINE_OE_O(so_oe), .OP_GO_O(op_go),
        .STATUS_O(status), .HW_LOCKED_STATE_O(hw_lck), .SW_GUARDED_STATE_O(sw_grd),
        .PROTECT_LEVEL_O(lvl), .PROTECT_FROM_BOTTOM_O(bot));

    // ==========================================
    // Shared helpers
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic cmd(input logic [7:0] code, input int n);
        host_u.frame({code, 40'h0}, n, rx);
    endtask

    task automatic wrsr(input logic [7:0] d, input int n);
        host_u.frame({CMD_ST_WRITE, d, 32'h0}, n, rx);
    endtask

    task automatic op(input logic whole, input logic [3:0] sec, input logic go);
        @(posedge clk);
        op_req <= 1'b1;
        op_whole <= whole;
        op_sector <= sec;
        @(posedge clk);
        op_req <= 1'b0;
        #1;
        chk(op_go, go, "op accept");
    endtask

    // ==========================================
    // Scenarios
    task automatic t_latch;
        chk({status, hw_lck, sw_grd, lvl, bot}, 14'h0010, "after reset");
        cmd(CMD_WR_GRANT, 9);
        chk(status, 8'h00, "odd length grant");
        cmd(CMD_WR_GRANT, 8);
        chk(status, 8'h02, "grant");
        cmd(CMD_ST_READ, 24);
        chk(rx[15:0], 16'h0202, "status read twice");
        cmd(CMD_WR_REVOKE, 8);
        chk(status, 8'h00, "revoke");
        $display("test latch done");
    endtask

    task automatic t_swrite;
        wrsr(8'hFF, 16);
        chk(status, 8'h00, "write without latch");
        cmd(CMD_WR_GRANT, 8);
        wrsr(8'hFF, 15);
        chk(status, 8'h02, "short write");
        wrsr(8'hFF, 16);
        chk({status, lvl}, 11'h47B, "write busy");
        wt(TW + 10);
        chk(status, 8'h8C, "write done");
        wp_b <= 1'b0;
        wt(5);
        chk({hw_lck, sw_grd}, 2'b10, "locked");
        cmd(CMD_WR_GRANT, 8);
        wrsr(8'h00, 16);
        wt(TW + 10);
        chk(status, 8'h8E, "locked write");
        wp_b <= 1'b1;
        wt(5);
        chk({hw_lck, sw_grd}, 2'b01, "unlocked");
        wrsr(8'h04, 16);
        wt(TW + 10);
        chk({status, lvl}, 11'h021, "unlocked write");
        $display("test status write done");
    endtask

    task automatic t_id_op;
        cmd(CMD_ID_READ, 48);
        chk(rx[39:0], {ID_CODE_DEF, FACT_LEN, FACT_DEF[127:120]}, "ident");
        chk(so_oe, 1'b0, "ident released");
        op(1'b0, 4'h0, 1'b0);
        cmd(CMD_WR_GRANT, 8);
        op(1'b1, 4'h0, 1'b0);
        op(1'b0, 4'hF, 1'b0);
        op(1'b0, 4'hE, 1'b1);
        cmd(CMD_ST_READ, 16);
        chk(rx[7:0], 8'h07, "busy read");
        fork
            cmd(CMD_ID_READ, 16);
            begin
                #1000;
                chk(so_oe, 1'b0, "ident while busy");
            end
        join
        wt(TOP + 10);
        chk(status, 8'h04, "op done");
        $display("test ident and ops done");
    endtask

    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================
    // Main sequence and watchdog
    initial
    begin
        rst_b = 1'b0;
        wp_b = 1'b1;
        op_req = 1'b0;
        op_whole = 1'b0;
        op_sector = 4'h0;
        mismatches = 0;
        checked = 0;
        wt(16);
        rst_b <= 1'b1;
        wt(4);
        t_latch();
        t_swrite();
        t_id_op();
        conclude();
    end

    initial
    begin
        #2000000;
        mismatches++;
        conclude();
    end
endmodule
